// File: verilog/ecd_regs.vh
`ifndef ECD_REGS_VH
`define ECD_REGS_VH
// register byte addresses
`define ECD_ADDR_CTRL     8'h00
`define ECD_ADDR_STATUS   8'h04
`define ECD_ADDR_ITEMSEL  8'h08
`define ECD_ADDR_TRIGCNT  8'h0C
`define ECD_ADDR_DAC0     8'h20
`define ECD_DAC_SPAN      8'h20
`define ECD_ADDR_W        8
// control register fields
`define ECD_CTRL_HOLD     0
`define ECD_CTRL_INTERVAL 1
`define ECD_CTRL_AVG      2
`define ECD_CTRL_PEAK     3
`define ECD_CTRL_AUTOOUT  4
`define ECD_CTRL_FNAME    5
`define ECD_CTRL_SCR_LO   8
`define ECD_CTRL_SCR_HI   9
`define ECD_CTRL_RESET    32'h0000_0000
// screen codes
`define ECD_SCR_MEASUREMENT 2'h0
`define ECD_SCR_SETTINGS  2'h1
`define ECD_SCR_DISK      2'h2
// item select: 4 bits per channel, bit 3 marks a harmonic/flicker item
`define ECD_ITEM_W        4
`define ECD_ITEM_HARM     3
`define ECD_ITEM_IDX_W    3
`define ECD_ITEMSEL_RESET 32'h0000_0000
`define ECD_NCHAN         8
`define ECD_NITEM         8
`define ECD_DAC_W         16
`define ECD_DAC_RESET     16'h0000
// contact pin positions and their idle, open level
`define ECD_PIN_RUN       0
`define ECD_PIN_CLEAR     1
`define ECD_PIN_REC       2
`define ECD_PIN_REFRESH   3
`define ECD_PINS_OPEN     4'hF
// trigger counter
`define ECD_TRIGCNT_RESET 16'h0000
`define ECD_TRIGCNT_STEP  16'h0001
// axi responses
`define ECD_RESP_OKAY     2'h0
`define ECD_RESP_SLVERR   2'h2
`endif

// File: verilog/ecd_ext_control.v
// Notes on behaviour
// - integration run input acts like the front-panel start/stop key; clear input clears integration.
// - each external start, stop or clear applies to all integrated items together.
// - external inputs stay active while the front-panel key lock is on.
// - recording trigger ignored while automatic periodic output is enabled.
// - one recording trigger requests disk and printer output together.
// - disk write without configured file name requests an automatic name.
// - under hold, each display refresh trigger updates held values once.
// - in peak hold, display refresh trigger clears the maximum and restarts.
// - eight converter channels, each with a non-harmonic item follows that item as displayed.
// - while hold is active, converter outputs keep frozen displayed values.
// - with hold and interval set, outputs refresh once per interval.
// - with averaging enabled, outputs carry averaged values.
// - harmonic or flicker results never reach the converter outputs.
// - on settings or disk screen, converter outputs freeze at last values.
// - outputs resume with new items only back on the measurement screen.
`timescale 1ns/100ps
`include "ecd_regs.vh"

module ecd_ext_control (
    // clock and reset
    input  wire         clk,
    input  wire         rstn,
    // control pins, low when closed to ground
    input  wire         integRunInputN,
    input  wire         integClearInputN,
    input  wire         recTrigInputN,
    input  wire         dispRefreshTrigN,
    input  wire         keyLock,
    // measurement side
    input  wire [127:0] instValues,
    input  wire [127:0] avgValues,
    input  wire         intervalTick,
    // actions towards the instrument
    output reg          integToggle,
    output reg          integClear,
    output reg          diskWriteReq,
    output reg          printReq,
    output reg          autoNameReq,
    output reg          holdUpdate,
    output reg          peakRestart,
    output reg  [127:0] dacOut,
    // axi4-lite slave
    input  wire [7:0]   s_axi_awaddr,
    input  wire         s_axi_awvalid,
    output reg          s_axi_awready,
    input  wire [31:0]  s_axi_wdata,
    input  wire [3:0]   s_axi_wstrb,
    input  wire         s_axi_wvalid,
    output reg          s_axi_wready,
    output reg  [1:0]   s_axi_bresp,
    output reg          s_axi_bvalid,
    input  wire         s_axi_bready,
    input  wire [7:0]   s_axi_araddr,
    input  wire         s_axi_arvalid,
    output reg          s_axi_arready,
    output reg  [31:0]  s_axi_rdata,
    output reg  [1:0]   s_axi_rresp,
    output reg          s_axi_rvalid,
    input  wire         s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    reg  [31:0] ctrl_reg;
    reg  [31:0] itemSel_reg;
    reg  [15:0] trigCnt_reg;
    reg  [3:0]  syncA_reg;
    reg  [3:0]  syncB_reg;
    reg  [3:0]  prevB_reg;
    reg  [7:0]  awAddr_reg;
    reg  [31:0] wData_reg;
    reg  [3:0]  wStrb_reg;
    reg         awHave_reg;
    reg         wHave_reg;
    reg         integRunning_reg;

    wire [3:0]  closedNow;
    wire [3:0]  closeEdge;
    wire        holdOn;
    wire        measurementScreen;
    wire        runEdge;
    wire        clearEdge;
    wire        recEdge;
    wire        refreshEdge;
    wire        dacUpdate;
    wire        recTake;
    wire        wrFire;
    wire [31:0] wrMask;
    wire [31:0] ctrl_next;
    wire [31:0] itemSel_next;
    wire [15:0] trigCnt_next;
    reg  [127:0] dac_next;
    reg  [`ECD_ITEM_IDX_W-1:0] itemIdx;
    reg  [31:0]  rdData;
    reg          rdOk;
    integer      ch;

    assign holdOn            = ctrl_reg[`ECD_CTRL_HOLD];
    assign measurementScreen =
        (ctrl_reg[`ECD_CTRL_SCR_HI:`ECD_CTRL_SCR_LO] == `ECD_SCR_MEASUREMENT);

    ////////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    // two-flop sync
    // pins are active low, inverted after the second flop only
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syncA_reg <= `ECD_PINS_OPEN;
            syncB_reg <= `ECD_PINS_OPEN;
            prevB_reg <= `ECD_PINS_OPEN;
        end else begin
            syncA_reg <= {dispRefreshTrigN, recTrigInputN, integClearInputN, integRunInputN};
            syncB_reg <= syncA_reg;
            prevB_reg <= syncB_reg;
        end
    end

    // closing edge detect
    // bounce would give extra edges; the far side keeps inputs clean
    assign closedNow = ~syncB_reg;
    assign closeEdge = closedNow & prevB_reg;

    // named closing edges, one per contact pin
    assign runEdge     = closeEdge[`ECD_PIN_RUN];
    assign clearEdge   = closeEdge[`ECD_PIN_CLEAR];
    assign recEdge     = closeEdge[`ECD_PIN_REC];
    assign refreshEdge = closeEdge[`ECD_PIN_REFRESH];

    assign recTake = recEdge & ~ctrl_reg[`ECD_CTRL_AUTOOUT];

    // wraps after 16 bits; software should work with differences
    assign trigCnt_next = trigCnt_reg + `ECD_TRIGCNT_STEP;

    ////////////////////////////////////////////////////////////////////////////////
    // converter update decision
    // freeze off measurement screen
    assign dacUpdate = measurementScreen & (~holdOn |
                       (ctrl_reg[`ECD_CTRL_INTERVAL] & intervalTick) |
                       refreshEdge);

    // harmonic items never routed
    // a harmonic channel keeps its last level rather than dropping to zero
    always @* begin
        dac_next = dacOut;
        itemIdx  = {`ECD_ITEM_IDX_W{1'b0}};
        for (ch = 0; ch < `ECD_NCHAN; ch = ch + 1) begin
            itemIdx = itemSel_reg[ch*`ECD_ITEM_W +: `ECD_ITEM_IDX_W];
            if (!itemSel_reg[ch*`ECD_ITEM_W + `ECD_ITEM_HARM]) begin
                if (ctrl_reg[`ECD_CTRL_AVG]) begin
                    dac_next[ch*`ECD_DAC_W +: `ECD_DAC_W] =
                        avgValues[itemIdx*`ECD_DAC_W +: `ECD_DAC_W];
                end else begin
                    dac_next[ch*`ECD_DAC_W +: `ECD_DAC_W] =
                        instValues[itemIdx*`ECD_DAC_W +: `ECD_DAC_W];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // action pulses
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            integToggle      <= 1'b0;
            integClear       <= 1'b0;
            diskWriteReq     <= 1'b0;
            printReq         <= 1'b0;
            autoNameReq      <= 1'b0;
            holdUpdate       <= 1'b0;
            peakRestart      <= 1'b0;
            integRunning_reg <= 1'b0;
            trigCnt_reg      <= `ECD_TRIGCNT_RESET;
            dacOut           <= {`ECD_NCHAN{`ECD_DAC_RESET}};
        end else begin
            integToggle <= runEdge;
            integClear  <= clearEdge;
            // clear wins if both pins close in the same cycle
            if (clearEdge) begin
                integRunning_reg <= 1'b0;
            end else if (runEdge) begin
                integRunning_reg <= ~integRunning_reg;
            end
            diskWriteReq <= recTake;
            printReq     <= recTake;
            autoNameReq  <= recTake & ~ctrl_reg[`ECD_CTRL_FNAME];
            // count only accepted triggers, so a masked one leaves no trace
            if (recTake) begin
                trigCnt_reg <= trigCnt_next;
            end
            holdUpdate  <= refreshEdge & holdOn;
            peakRestart <= refreshEdge & ctrl_reg[`ECD_CTRL_PEAK];
            // dacUpdate already folds in screen, hold and interval
            if (dacUpdate) begin
                dacOut <= dac_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite write path: address and data taken in either order
    assign wrFire = awHave_reg & wHave_reg & ~s_axi_bvalid;
    // byte strobes pick the lanes that a write may change
    assign wrMask = {{8{wStrb_reg[3]}}, {8{wStrb_reg[2]}}, {8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};
    assign ctrl_next    = (ctrl_reg & ~wrMask) | (wData_reg & wrMask);
    assign itemSel_next = (itemSel_reg & ~wrMask) | (wData_reg & wrMask);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ECD_RESP_OKAY;
            awHave_reg    <= 1'b0;
            wHave_reg     <= 1'b0;
            awAddr_reg    <= 8'h00;
            wData_reg     <= 32'h0000_0000;
            wStrb_reg     <= 4'h0;
            ctrl_reg      <= `ECD_CTRL_RESET;
            itemSel_reg   <= `ECD_ITEMSEL_RESET;
        end else begin
            // ready is a one-cycle pulse that accepts the offered item
            s_axi_awready <= s_axi_awvalid & ~awHave_reg & ~s_axi_awready;
            s_axi_wready  <= s_axi_wvalid & ~wHave_reg & ~s_axi_wready;
            if (s_axi_awvalid & s_axi_awready) begin
                awHave_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                wHave_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            if (wrFire) begin
                awHave_reg   <= 1'b0;
                wHave_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `ECD_RESP_OKAY;
                case (awAddr_reg)
                    `ECD_ADDR_CTRL:    ctrl_reg    <= ctrl_next;
                    `ECD_ADDR_ITEMSEL: itemSel_reg <= itemSel_next;
                    default:           s_axi_bresp <= `ECD_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite read decode; status shows live pins and integration state
    always @* begin
        rdData = 32'h0000_0000;
        rdOk   = 1'b1;
        // dac words mirror the outputs; only aligned words answer
        if (s_axi_araddr >= `ECD_ADDR_DAC0 &&
            s_axi_araddr < `ECD_ADDR_DAC0 + `ECD_DAC_SPAN && s_axi_araddr[1:0] == 2'h0) begin
            rdData[`ECD_DAC_W-1:0] = dacOut[s_axi_araddr[4:2]*`ECD_DAC_W +: `ECD_DAC_W];
        end else begin
            case (s_axi_araddr)
                `ECD_ADDR_CTRL:    rdData = ctrl_reg;
                `ECD_ADDR_STATUS:  rdData = {26'h0, keyLock, integRunning_reg, closedNow};
                `ECD_ADDR_ITEMSEL: rdData = itemSel_reg;
                `ECD_ADDR_TRIGCNT: rdData = {16'h0000, trigCnt_reg};
                default:           rdOk   = 1'b0;
            endcase
        end
    end

    // read answers one cycle after address acceptance
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `ECD_RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rdData;
                s_axi_rresp  <= rdOk ? `ECD_RESP_OKAY : `ECD_RESP_SLVERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // ecd_ext_control

// File: test/ecd_pin_driver.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
// far-side contacts; a closed contact pulls its pin low
module ecd_pin_driver #(
    parameter int HOLD_CYC = 12,
    parameter int GAP_CYC  = 12
) (
    // clock
    input  wire logic       clk,
    // contact pins: run, clear, record, refresh
    output logic      [3:0] pinN
);
    // all contacts open at start
    initial pinN = 4'hF;
    // clean closure, held, then spaced
    // scaled hold and gap keep the run short
    task automatic press(input int p);
        @(posedge clk);
        pinN[p] <= 1'b0;
        repeat (HOLD_CYC) @(posedge clk);
        pinN[p] <= 1'b1;
        repeat (GAP_CYC) @(posedge clk);
    endtask
endmodule // ecd_pin_driver

// File: test/ecd_ext_control_checker.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
// pin-to-action relations of the control block
module ecd_ext_control_checker (
    // clock and reset
    input wire clk,
    input wire rstn,
    // contact pins, low when closed
    input wire integRunInputN,
    input wire integClearInputN,
    input wire recTrigInputN,
    input wire dispRefreshTrigN,
    // action pulses
    input wire integToggle,
    input wire integClear,
    input wire diskWriteReq,
    input wire printReq,
    input wire autoNameReq,
    input wire holdUpdate,
    input wire peakRestart
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // two sync flops and an edge register bound the lag
    run_pulse_a: assert property ($fell(integRunInputN) |-> ##[2:5] integToggle)
        else $error("run closure gave no toggle");
    clear_pulse_a: assert property ($fell(integClearInputN) |-> ##[2:5] integClear)
        else $error("clear closure gave no clear");
    toggle_cause_a: assert property (integToggle |-> !$past(integRunInputN, 2))
        else $error("toggle without closed run pin");
    rec_cause_a: assert property (diskWriteReq |-> !$past(recTrigInputN, 2))
        else $error("disk request without closed record pin");
    refresh_cause_a: assert property ((holdUpdate || peakRestart) |->
        !$past(dispRefreshTrigN, 2))
        else $error("refresh action without closed pin");
    rec_pair_a: assert property (printReq == diskWriteReq)
        else $error("disk and print requests apart");
    auto_name_a: assert property (autoNameReq |-> diskWriteReq)
        else $error("auto name without disk write");
    one_pulse_a: assert property ((integToggle || integClear) |=>
        !(integToggle || integClear))
        else $error("integration action longer than one cycle");
endmodule // ecd_ext_control_checker

bind ecd_ext_control ecd_ext_control_checker u_ecd_ext_control_checker (
    .clk(clk), .rstn(rstn), .integRunInputN(integRunInputN),
    .integClearInputN(integClearInputN), .recTrigInputN(recTrigInputN),
    .dispRefreshTrigN(dispRefreshTrigN), .integToggle(integToggle),
    .integClear(integClear), .diskWriteReq(diskWriteReq), .printReq(printReq),
    .autoNameReq(autoNameReq), .holdUpdate(holdUpdate), .peakRestart(peakRestart));

// File: test/ecd_ext_control_tb.sv
`timescale 1ns/100ps
`include "ecd_regs.vh"
module ecd_ext_control_tb;
    logic         clk = 0, rstn = 0, tick = 0, keyLock = 1;
    logic [127:0] inst = 0, avg = 0;
    logic [7:0]   awaddr = 0, araddr = 0;
    logic [31:0]  wdata = 0, rd;
    logic         awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic [1:0]   rsp;
    wire  [3:0]   pinN;
    wire          awready, wready, bvalid, arready, rvalid;
    wire  [1:0]   bresp, rresp;
    wire  [31:0]  rdata;
    wire  [127:0] dac;
    wire  [6:0]   act;
    int           cnt [7], ecnt [7], err_total = 0, comparisons = 0;

    initial forever #2.5 clk = ~clk;
    ecd_pin_driver u_ecd_pin_driver (.clk(clk), .pinN(pinN));
    ecd_ext_control u_ecd_ext_control (.clk(clk), .rstn(rstn),
        .integRunInputN(pinN[0]), .integClearInputN(pinN[1]),
        .recTrigInputN(pinN[2]), .dispRefreshTrigN(pinN[3]), .keyLock(keyLock),
        .instValues(inst), .avgValues(avg), .intervalTick(tick),
        .integToggle(act[0]), .integClear(act[1]), .diskWriteReq(act[2]),
        .printReq(act[3]), .autoNameReq(act[4]), .holdUpdate(act[5]),
        .peakRestart(act[6]), .dacOut(dac), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    // tally action pulses; an unknown never counts
    always @(posedge clk)
        for (int i = 0; i < 7; i++) if (act[i] === 1'b1) cnt[i]++;
    ////////////////////////////////////////////////////////////
    task chk(input string n, input logic [31:0] e, s);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    // write: address and data offered together, each dropped once taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1;
        wv <= 1;
        bready <= 1;
        while (awv || wv || !bvalid) begin
            @(posedge clk);
            if (awready) awv <= 0;
            if (wready) wv <= 0;
        end
        rsp = bresp;
        bready <= 0;
    endtask
    task rdr(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arv <= 1;
        rready <= 1;
        while (arv || !rvalid) begin
            @(posedge clk);
            if (arready) arv <= 0;
        end
        rd = rdata;
        rsp = rresp;
        rready <= 0;
    endtask
    // close pin p, then compare every action tally
    task pr(input int p, input logic [6:0] m);
        u_ecd_pin_driver.press(p);
        for (int i = 0; i < 7; i++) begin
            ecnt[i] += m[i];
            chk("actions", ecnt[i], cnt[i]);
        end
    endtask
    // channel c carries item c; channel 7 is a harmonic item and stays 0
    task chkDac(input logic [15:0] b);
        repeat (6) @(posedge clk);
        for (int c = 0; c < 7; c++) chk("dac", b + c, dac[16*c +: 16]);
        chk("dac7", 0, dac[127:112]);
    endtask
    // averaged values sit 0x1000 above instantaneous ones
    task setSrc(input logic [15:0] b);
        @(posedge clk);
        for (int k = 0; k < 8; k++) begin
            inst[16*k +: 16] <= b + k;
            avg[16*k +: 16] <= b + 16'h1000 + k;
        end
    endtask
    task finish_test;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // watchdog: the sequence needs a few hundred cycles
    initial begin
        #100000;
        err_total++;
        finish_test;
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1;
        chk("dac reset", 0, dac[31:0]);
        rdr(`ECD_ADDR_CTRL);
        chk("ctrl", `ECD_CTRL_RESET, rd);
        chk("ctrl rresp", `ECD_RESP_OKAY, rsp);
        rdr(`ECD_ADDR_ITEMSEL);
        chk("itemsel", `ECD_ITEMSEL_RESET, rd);
        rdr(8'h10);
        chk("unmapped rd", `ECD_RESP_SLVERR, rsp);
        wr(8'h10, 32'h1);
        chk("unmapped wr", `ECD_RESP_SLVERR, rsp);
        pr(0, 7'h01);
        rdr(`ECD_ADDR_STATUS);
        chk("status", 32'h30, rd & 32'h30);
        pr(1, 7'h02);
        pr(2, 7'h1C);
        wr(`ECD_ADDR_CTRL, 32'h20);
        chk("ctrl bresp", `ECD_RESP_OKAY, rsp);
        pr(2, 7'h0C);
        wr(`ECD_ADDR_CTRL, 32'h30);
        pr(2, 7'h00);
        rdr(`ECD_ADDR_TRIGCNT);
        chk("trigcnt", 2, rd);
        wr(`ECD_ADDR_ITEMSEL, 32'hF6543210);
        setSrc(16'h1000);
        wr(`ECD_ADDR_CTRL, 0);
        chkDac(16'h1000);
        rdr(`ECD_ADDR_DAC0);
        chk("dac0 reg", 32'h1000, rd);
        wr(`ECD_ADDR_CTRL, 32'h4);
        chkDac(16'h2000);
        wr(`ECD_ADDR_CTRL, 32'h1);
        setSrc(16'h3000);
        @(posedge clk) tick <= 1;
        @(posedge clk) tick <= 0;
        chkDac(16'h2000);
        pr(3, 7'h20);
        chkDac(16'h3000);
        wr(`ECD_ADDR_CTRL, 32'h3);
        setSrc(16'h4000);
        chkDac(16'h3000);
        @(posedge clk) tick <= 1;
        @(posedge clk) tick <= 0;
        chkDac(16'h4000);
        wr(`ECD_ADDR_CTRL, 32'h100);
        setSrc(16'h5000);
        chkDac(16'h4000);
        wr(`ECD_ADDR_CTRL, 32'h200);
        chkDac(16'h4000);
        wr(`ECD_ADDR_CTRL, 0);
        chkDac(16'h5000);
        wr(`ECD_ADDR_CTRL, 32'h8);
        pr(3, 7'h40);
        finish_test;
    end
endmodule // ecd_ext_control_tb
